// *** qiocr_pkg.sv ***
package qiocr_pkg;

    // ------------------------------------------------------------------
    // Command codes and field values
    // ------------------------------------------------------------------
    localparam logic [7:0]  QUAD_IO_READ_CMD           = 8'heb;
    localparam logic [7:0]  QUAD_IO_READ_FOUR_BYTE_CMD = 8'hec;
    localparam logic [3:0]  CONT_MODE_NIBBLE           = 4'ha;
    localparam logic [31:0] ADDR3_MASK                 = 32'h00ffffff;

    // ------------------------------------------------------------------
    // Phase lengths in link clock rising edges; CMD_LAST is the last count of the 8-edge command
    // ------------------------------------------------------------------
    localparam logic [3:0]  CMD_LAST      = 4'h7;
    localparam logic [3:0]  ADDR3_NIBBLES = 4'h6;
    localparam logic [3:0]  ADDR4_NIBBLES = 4'h8;
    localparam logic [3:0]  MODE_NIBBLES  = 4'h2;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [5:0]  SYNC_RST  = 6'h20;
    localparam logic [3:0]  IO_RST    = 4'h0;
    localparam logic [3:0]  CNT_RST   = 4'h0;
    localparam logic [7:0]  CMD_RST   = 8'h00;
    localparam logic [31:0] ADDR_RST  = 32'h00000000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_ADDR,
        ST_DUMMY,
        ST_DATA,
        ST_IGNORE
    } qiocr_state_t;

endpackage

// *** qiocr_buf.sv ***
module qiocr_buf #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         flush_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    import qiocr_pkg::*;

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Pointers wrap naturally, so only powers of two are served.
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("qiocr_buf: DEPTH must be a power of two, at least 2");
    end

    logic [W-1:0]  mem_r [DEPTH];
    logic [PW-1:0] wr_r;
    logic [PW-1:0] rd_r;
    logic [PW:0]   cnt_r;
    logic          push;
    logic          pop;

    assign in_ready_o  = (cnt_r != (PW+1)'(DEPTH)) && !flush_i;
    assign out_valid_o = (cnt_r != '0) && !flush_i;
    assign out_data_o  = mem_r[rd_r];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem_r[wr_r] <= in_data_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i || flush_i) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            wr_r  <= push ? wr_r + 1'b1 : wr_r;
            rd_r  <= pop ? rd_r + 1'b1 : rd_r;
            cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule // qiocr_buf

// *** qiocr_core.sv ***
module qiocr_core #(
    parameter int BUF_DEPTH = 2
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        sck_i,
    input  wire logic        ce_b_i,
    input  wire logic [3:0]  io_i,
    output logic [3:0]       io_o,
    output logic             io_oe_o,
    input  wire logic        write_in_progress_flag_i,
    input  wire logic        extended_address_setting_i,
    input  wire logic [3:0]  dummy_cycles_i,
    output logic [31:0]      mem_addr_o,
    output logic             mem_active_o,
    input  wire logic [7:0]  mem_rdata_i,
    input  wire logic        mem_rvalid_i,
    output logic             mem_rready_o,
    output logic             continuous_read_mode_o
);
    import qiocr_pkg::*;

    // Refuse a read-ahead depth that cannot cover the current byte.
    if (BUF_DEPTH < 2) begin : g_bad_depth
        $error("qiocr_core: BUF_DEPTH must be at least 2");
    end

    // ------------------------------------------------------------------
    // Pin synchronisers and link clock edges
    // ------------------------------------------------------------------
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    logic       sck_d_r;
    logic       ce_b_s;
    logic       sck_s;
    logic [3:0] io_s;
    logic       rise;
    logic       fall;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            sync1_r <= SYNC_RST;
            sync2_r <= SYNC_RST;
            sck_d_r <= 1'b0;
        end else begin
            sync1_r <= {ce_b_i, sck_i, io_i};
            sync2_r <= sync1_r;
            sck_d_r <= sync2_r[4];
        end
    end

    assign ce_b_s = sync2_r[5];
    assign sck_s  = sync2_r[4];
    assign io_s   = sync2_r[3:0];
    assign rise   = sck_s && !sck_d_r;
    assign fall   = !sck_s && sck_d_r;

    // ------------------------------------------------------------------
    // Frame sequencing
    // ------------------------------------------------------------------
    qiocr_state_t state_r;
    logic [3:0]   cnt_r;
    logic [7:0]   cmd_sr_r;
    logic [31:0]  addr_sr_r;
    logic         four_r;
    logic         cont_r;
    logic [3:0]   mode_hi_r;
    logic [7:0]   cmd_byte;
    logic [31:0]  addr_full;
    logic [3:0]   addr_nib;
    logic [3:0]   dummy_eff;
    logic         cmd_last;
    logic         addr_last;
    logic         mode_last;
    logic         dummy_last;
    logic         is_qio;

    assign cmd_byte  = {cmd_sr_r[6:0], io_s[0]};
    assign is_qio    = (cmd_byte == QUAD_IO_READ_CMD)
                    || (cmd_byte == QUAD_IO_READ_FOUR_BYTE_CMD);
    assign addr_nib  = four_r ? ADDR4_NIBBLES : ADDR3_NIBBLES;
    assign addr_full = four_r ? {addr_sr_r[27:0], io_s}
                              : ({addr_sr_r[27:0], io_s} & ADDR3_MASK);
    // Counts shorter than the mode field are stretched to cover it.
    assign dummy_eff = (dummy_cycles_i < MODE_NIBBLES) ? MODE_NIBBLES
                                                       : dummy_cycles_i;
    assign cmd_last  = (state_r == ST_CMD) && rise && (cnt_r == CMD_LAST);
    assign addr_last = (state_r == ST_ADDR) && rise
                    && (cnt_r == addr_nib - 4'h1);
    assign mode_last = (state_r == ST_DUMMY) && rise
                    && (cnt_r == MODE_NIBBLES - 4'h1);
    assign dummy_last = (state_r == ST_DUMMY) && rise
                     && (cnt_r >= dummy_eff - 4'h1);

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i || ce_b_s) begin
            state_r <= ST_IDLE;
            cnt_r   <= CNT_RST;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    cnt_r <= CNT_RST;
                    if (!cont_r) begin
                        state_r <= ST_CMD;
                    end else if (write_in_progress_flag_i) begin
                        state_r <= ST_IGNORE;
                    end else begin
                        state_r <= ST_ADDR;
                    end
                end
                ST_CMD: begin
                    if (cmd_last) begin
                        cnt_r <= CNT_RST;
                        if (is_qio && !write_in_progress_flag_i) begin
                            state_r <= ST_ADDR;
                        end else begin
                            state_r <= ST_IGNORE;
                        end
                    end else if (rise) begin
                        cnt_r <= cnt_r + 4'h1;
                    end
                end
                ST_ADDR: begin
                    if (addr_last) begin
                        cnt_r   <= CNT_RST;
                        state_r <= ST_DUMMY;
                    end else if (rise) begin
                        cnt_r <= cnt_r + 4'h1;
                    end
                end
                ST_DUMMY: begin
                    if (dummy_last) begin
                        cnt_r   <= CNT_RST;
                        state_r <= ST_DATA;
                    end else if (rise) begin
                        cnt_r <= cnt_r + 4'h1;
                    end
                end
                ST_DATA: begin
                    state_r <= ST_DATA;
                end
                ST_IGNORE: begin
                    state_r <= ST_IGNORE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            cmd_sr_r  <= CMD_RST;
            addr_sr_r <= ADDR_RST;
            mode_hi_r <= IO_RST;
        end else if (rise) begin
            if (state_r == ST_CMD) begin
                cmd_sr_r <= cmd_byte;
            end
            if (state_r == ST_ADDR) begin
                addr_sr_r <= {addr_sr_r[27:0], io_s};
            end
            if (state_r == ST_DUMMY && cnt_r == CNT_RST) begin
                mode_hi_r <= io_s;
            end
        end
    end

    // ------------------------------------------------------------------
    // Address width and continuous read flag
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            four_r <= 1'b0;
        end else if (cmd_last && is_qio && !write_in_progress_flag_i) begin
            four_r <= (cmd_byte == QUAD_IO_READ_FOUR_BYTE_CMD)
                   || extended_address_setting_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            cont_r <= 1'b0;
        end else if (mode_last) begin
            // The low mode nibble is never looked at.
            cont_r <= (mode_hi_r == CONT_MODE_NIBBLE);
        end
    end

    assign continuous_read_mode_o = cont_r;

    // ------------------------------------------------------------------
    // Array fetch into the read-ahead buffer
    // ------------------------------------------------------------------
    logic       buf_in_ready;
    logic       buf_out_valid;
    logic [7:0] buf_out_data;
    logic       buf_pop;
    logic       fetch_take;
    logic       nib_lo_r;

    assign mem_rready_o = buf_in_ready && mem_active_o;
    assign fetch_take   = mem_rvalid_i && mem_rready_o;
    assign buf_pop      = (state_r == ST_DATA) && fall && !nib_lo_r
                       && buf_out_valid;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i || ce_b_s) begin
            mem_active_o <= 1'b0;
        end else if (addr_last) begin
            mem_active_o <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            mem_addr_o <= ADDR_RST;
        end else if (addr_last) begin
            mem_addr_o <= addr_full;
        end else if (fetch_take) begin
            // Natural roll-over takes the top 32-bit address back to zero; a 3-byte address runs on past 24 bits.
            mem_addr_o <= mem_addr_o + 32'h00000001;
        end
    end

    qiocr_buf #(
        .W     (8),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .ref_clk_i   (ref_clk_i),
        .rst_b_i     (rst_b_i),
        .flush_i     (ce_b_s),
        .in_valid_i  (mem_rvalid_i && mem_active_o),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (mem_rdata_i),
        .out_valid_o (buf_out_valid),
        .out_ready_i (buf_pop),
        .out_data_o  (buf_out_data)
    );

    // ------------------------------------------------------------------
    // Nibble-serial data output on the falling link clock edge
    // ------------------------------------------------------------------
    logic [3:0] lo_r;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i || ce_b_s) begin
            io_o     <= IO_RST;
            io_oe_o  <= 1'b0;
            lo_r     <= IO_RST;
            nib_lo_r <= 1'b0;
        end else if (state_r == ST_DATA && fall) begin
            // Lines are driven only once the dummy period is over.
            io_oe_o  <= 1'b1;
            nib_lo_r <= !nib_lo_r;
            if (!nib_lo_r) begin
                io_o <= buf_out_data[7:4];
                lo_r <= buf_out_data[3:0];
            end else begin
                io_o <= lo_r;
            end
        end
    end
endmodule // qiocr_core

// *** qiocr_core_asserts.sv ***
module qiocr_chk #(
    parameter int BUF_DEPTH = 2
) (
    input wire logic        ref_clk_i,
    input wire logic        rst_b_i,
    input wire logic        ce_b_i,
    input wire logic        io_oe_o,
    input wire logic        write_in_progress_flag_i,
    input wire logic [31:0] mem_addr_o,
    input wire logic        mem_active_o,
    input wire logic        mem_rvalid_i,
    input wire logic        mem_rready_o,
    input wire logic        continuous_read_mode_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    // ------
    // Frame end and output enable
    // ------
    a_oe_off_desel: assert property (
        ce_b_i [*5] |-> !io_oe_o) else $error("lines driven while idle");
    a_act_off_desel: assert property (
        ce_b_i [*5] |-> !mem_active_o) else $error("fetch active while idle");
    a_oe_holds: assert property (
        (!ce_b_i) [*4] ##0 io_oe_o |=> io_oe_o) else $error("output dropped");
    a_oe_after_addr: assert property (
        $rose(io_oe_o) |-> mem_active_o) else $error("output before address");

    // ------
    // Address stream
    // ------
    a_addr_step: assert property (
        mem_active_o && mem_rvalid_i && mem_rready_o
        |=> mem_addr_o == $past(mem_addr_o) + 32'h1)
        else $error("address did not advance by one");
    a_addr_hold: assert property (
        mem_active_o && !(mem_rvalid_i && mem_rready_o) ##1 mem_active_o
        |-> $stable(mem_addr_o)) else $error("address moved without byte");

    // ------
    // Mode and busy
    // ------
    a_wip_no_data: assert property (
        $rose(io_oe_o) |-> !write_in_progress_flag_i)
        else $error("read served while busy");
    a_wip_keeps_mode: assert property (
        $changed(continuous_read_mode_o) |-> !write_in_progress_flag_i)
        else $error("mode changed while busy");
    a_mode_idle: assert property (
        ce_b_i [*4] |=> $stable(continuous_read_mode_o))
        else $error("mode changed outside a frame");
    c_buf_full: cover property (mem_active_o && !mem_rready_o);
endmodule // qiocr_chk

bind qiocr_core qiocr_chk #(.BUF_DEPTH(BUF_DEPTH)) u_chk (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ce_b_i(ce_b_i),
    .io_oe_o(io_oe_o), .mem_addr_o(mem_addr_o),
    .write_in_progress_flag_i(write_in_progress_flag_i),
    .mem_active_o(mem_active_o), .mem_rvalid_i(mem_rvalid_i),
    .mem_rready_o(mem_rready_o),
    .continuous_read_mode_o(continuous_read_mode_o)
);

// *** qiocr_host.sv ***
module qiocr_host (
    input  wire logic       ref_clk_i,
    input  wire logic [3:0] dev_io_i,
    input  wire logic       dev_oe_i,
    output logic            sck_o,
    output logic            ce_b_o,
    output logic [3:0]      io_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] q, drv_v = 4'h0, last = 4'h0;
    logic       drv = 1'b0;
    logic [7:0] rx[$];

    // A released line shows the inverse of its last driven level.
    assign io_o = dev_oe_i ? dev_io_i : (drv ? drv_v : ~last);

    initial begin
        sck_o = 1'b0;
        ce_b_o = 1'b1;
    end

    task automatic cyc(input logic [3:0] v, input logic d);
        drv_v = v;
        drv = d;
        if (d) last = v;
        #200 sck_o = 1'b1;
        q = io_o;
        #200 sck_o = 1'b0;
    endtask

    task automatic frame(input logic cmd_en, input logic [7:0] cmd,
                         input logic [31:0] a, input int an,
                         input logic [7:0] m, input int dm, input int nb);
        logic [3:0] hi;
        rx.delete();
        ce_b_o = 1'b0;
        if (cmd_en) for (int i = 7; i >= 0; i--) cyc({3'h0, cmd[i]}, 1'b1);
        for (int i = an - 1; i >= 0; i--) cyc(a[4*i +: 4], 1'b1);
        cyc(m[7:4], 1'b1);
        cyc(m[3:0], dm > 2);
        for (int i = 2; i < dm; i++) cyc(4'h0, 1'b0);
        for (int i = 0; i < nb; i++) begin
            cyc(4'h0, 1'b0);
            hi = q;
            cyc(4'h0, 1'b0);
            rx.push_back({hi, q});
        end
        drv = 1'b0;
        #200 ce_b_o = 1'b1;
        #400;
    endtask
endmodule // qiocr_host

// *** tb_qiocr_core.sv ***
module tb_qiocr_core;
    timeunit 1ns;
    timeprecision 1ns;
    import qiocr_pkg::*;
    logic        ref_clk = 0, rst_b = 0, write_in_progress_flag = 0, ext = 0, rvalid = 0;
    logic        sck, ce_b, oe, act, rready, cont;
    logic [3:0]  dummy = 4'h6, io_in, io_out;
    logic [31:0] mem_addr;
    int          error_cnt = 0, comparisons = 0, oe_cnt = 0;

    always #25 ref_clk = ~ref_clk;
    always @(negedge ref_clk) rvalid <= ($urandom_range(3) != 0);
    always @(posedge ref_clk) if (oe === 1'b1) oe_cnt++;

    function automatic logic [7:0] exp_b(input logic [31:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ a[31:24] ^ 8'h3c;
    endfunction

    qiocr_core dut (
        .ref_clk_i(ref_clk), .rst_b_i(rst_b), .sck_i(sck), .ce_b_i(ce_b),
        .io_i(io_in), .io_o(io_out), .io_oe_o(oe),
        .write_in_progress_flag_i(write_in_progress_flag), .extended_address_setting_i(ext),
        .dummy_cycles_i(dummy), .mem_addr_o(mem_addr), .mem_active_o(act),
        .mem_rdata_i(exp_b(mem_addr)), .mem_rvalid_i(rvalid),
        .mem_rready_o(rready), .continuous_read_mode_o(cont)
    );
    qiocr_host u_host (
        .ref_clk_i(ref_clk), .dev_io_i(io_out), .dev_oe_i(oe),
        .sck_o(sck), .ce_b_o(ce_b), .io_o(io_in)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("comparisons=%0d errors=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #500000;
        error_cnt++;
        complete_run();
    end

    initial begin
        logic [31:0] a;
        logic [7:0]  c, m;
        logic        cx, ok, w;
        int          an, dm, nb, r;
        cx = 1'b0;
        an = 6;
        void'($urandom(52411));
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk(32'({cont, oe, act}), 32'h0);
        for (int i = 0; i < 24; i++) begin
            @(negedge ref_clk);
            if (i == 12) begin
                rst_b = 1'b0;
                repeat (6) @(negedge ref_clk);
                rst_b = 1'b1;
                cx = 1'b0;
                repeat (4) @(negedge ref_clk);
                chk(32'({cont, oe, act}), 32'h0);
            end
            r = $urandom_range(7);
            c = r == 0 ? 8'h03 : r[0] ? QUAD_IO_READ_CMD
                                      : QUAD_IO_READ_FOUR_BYTE_CMD;
            ext = 1'($urandom);
            w = ($urandom_range(4) == 0);
            m = {r[1] ? CONT_MODE_NIBBLE : 4'($urandom), 4'($urandom)};
            dm = $urandom_range(8, 2);
            nb = $urandom_range(5, 1);
            a = $urandom;
            if (i < 2) begin
                w = 1'b0;
                m = i ? 8'h3a : 8'ha5;
            end
            if (i == 0) begin
                a = 32'hfffffffe;
                c = QUAD_IO_READ_FOUR_BYTE_CMD;
                dm = 2;
            end
            write_in_progress_flag = w;
            // The first test asks for no dummies; two are still kept.
            dummy = (i == 0) ? 4'h0 : 4'(dm);
            if (!cx) an = (c == QUAD_IO_READ_FOUR_BYTE_CMD || ext) ? 8 : 6;
            ok = !w && (cx || c == QUAD_IO_READ_CMD
                           || c == QUAD_IO_READ_FOUR_BYTE_CMD);
            oe_cnt = 0;
            u_host.frame(!cx, c, a, an, m, dm, nb);
            chk(32'({oe, act, rready}), 32'h0);
            if (ok) begin
                if (an == 6) a = a & ADDR3_MASK;
                for (int k = 0; k < nb; k++)
                    chk(32'(u_host.rx[k]), 32'(exp_b(a + k)));
                cx = (m[7:4] == CONT_MODE_NIBBLE);
            end else begin
                chk(32'(oe_cnt), 32'h0);
            end
            chk(32'(cont), 32'(cx));
            $display("test %0d done", i);
        end
        complete_run();
    end
endmodule // tb_qiocr_core
